// ---- logic/dlo_consts.svh ----
// Constants for the DLL on/off switching controller and memory model.
// Assumes a 125 MHz reference clock; all counts are in its rising edges.
`ifndef DLO_CONSTS_SVH
`define DLO_CONSTS_SVH

// Clock period and timer width
`define DLO_CLK_PS      8000
`define DLO_TW          10

// Times in their own units, then cycles rounded up
`define DLO_TXS_NS      170
`define DLO_TXS_CYC     ((`DLO_TXS_NS*1000+`DLO_CLK_PS-1)/`DLO_CLK_PS)
`define DLO_TCKSRE_NS   10
`define DLO_TCKSRE_NCK  5
`define DLO_TCKSRE_RU   ((`DLO_TCKSRE_NS*1000+`DLO_CLK_PS-1)/`DLO_CLK_PS)
`define DLO_TCKSRE_CYC  ((`DLO_TCKSRE_RU>`DLO_TCKSRE_NCK)?`DLO_TCKSRE_RU:`DLO_TCKSRE_NCK)
`define DLO_TCKSRX_CYC  5
`define DLO_TMOD_CYC    12
`define DLO_TMRD_CYC    4
`define DLO_TDLLK_CYC   512
`define DLO_TZQOPER_CYC 256

// Mode register bit positions and values
`define DLO_MR1_DLL_DIS 0
`define DLO_MR0_DLL_RST 8
`define DLO_CL_OFF      6
`define DLO_CWL_OFF     6
`define DLO_MR0_OFF     14'h0020
`define DLO_MR0_ON      14'h0050
`define DLO_MR0_RST     14'h0150
`define DLO_MR1_OFF     14'h0001
`define DLO_MR1_ON      14'h0000
`define DLO_MR2_OFF     14'h0008
`define DLO_MR2_ON      14'h0010

// Register offsets and fields
`define DLO_REG_CTRL    4'h0
`define DLO_REG_STAT    4'h4
`define DLO_REG_RDATA   4'h8
`define DLO_CTRL_GO     0
`define DLO_CTRL_OFF    1
`define DLO_CTRL_ZQ     2
`define DLO_CTRL_RD     3
`define DLO_STAT_BUSY   0
`define DLO_STAT_DLLOFF 1
`define DLO_STAT_DONE   2
`define DLO_STAT_SLOW   3

`endif

// ---- logic/dlo_pkg.sv ----
// Types shared by both ends of the DLL switching link.
// Assumes nothing beyond the constants header.
`default_nettype none
package dlo_pkg;
  // Decoded memory command
  typedef enum logic [2:0] {
    DLO_NOP, DLO_MRS, DLO_REF, DLO_RD, DLO_ZQ, DLO_OTHER
  } dlo_cmd_e;

  // Controller sequence states
  typedef enum logic [3:0] {
    ST_IDLE, ST_MR1OFF, ST_SRE, ST_CLKCHG, ST_SRX, ST_MR1ON, ST_MR0RST,
    ST_MR2, ST_MR0, ST_ZQ, ST_FIN, ST_RD, ST_WRD, ST_WAIT
  } dlo_st_e;

  // Command decode from the four control pins
  function automatic dlo_cmd_e dlo_decode(input logic cs_n, input logic ras_n,
                                          input logic cas_n, input logic we_n);
    if (cs_n)
      return DLO_NOP;
    case ({ras_n, cas_n, we_n})
      3'b111:  return DLO_NOP;
      3'b000:  return DLO_MRS;
      3'b001:  return DLO_REF;
      3'b101:  return DLO_RD;
      3'b110:  return DLO_ZQ;
      default: return DLO_OTHER;
    endcase
  endfunction : dlo_decode
endpackage : dlo_pkg
`default_nettype wire

// ---- logic/dlo_if.sv ----
// Command, clock-select and read-return link between controller and memory.
// Both ends run on the same reference clock; the bench joins them here.
`default_nettype none
interface dlo_if;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [2:0]  ba;
  logic [13:0] addr;
  logic        odt;
  logic        ck_slow;   // High while the slow DLL-off clock rate is chosen
  logic        rd_dqs;    // Read strobe, high for each returned beat
  logic [15:0] rd_dq;

  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, ck_slow,
               input rd_dqs, rd_dq);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, ck_slow,
               output rd_dqs, rd_dq);
endinterface : dlo_if
`default_nettype wire

// ---- logic/dlo_tmr.sv ----
// Down counter for the controller's wait intervals.
// Counts real reference clock edges; loading restarts it.
`include "dlo_consts.svh"
`default_nettype none
module dlo_tmr
  import dlo_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                rstn_i,
  input  wire logic                load_i,
  input  wire logic [`DLO_TW-1:0]  cnt_i,
  output logic                     done_o
);
  logic [`DLO_TW-1:0] cnt;

  // Each edge is one cycle whatever the period, so slow clocks stretch waits
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      cnt <= '0;
    else if (load_i)
      cnt <= cnt_i;
    else if (cnt != '0)
      cnt <= cnt - 1'b1;
  end

  assign done_o = (cnt == '0) && !load_i;
endmodule : dlo_tmr
`default_nettype wire

// ---- logic/dlo_dev.sv ----
// Memory-side model: mode registers, DLL state, self refresh, read latency.
// Assumes the controller keeps its own sequencing rules on the link.
`include "dlo_consts.svh"
`default_nettype none
module dlo_dev
  import dlo_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  dlo_if.dev        lnk,
  output logic      dll_off_o,
  output logic      dll_locked_o,
  output logic      self_ref_o,
  output logic      lat_bad_o,
  output logic      clk_err_o
);
  dlo_cmd_e    cmd;
  logic        cke_q;
  logic [13:0] mr0, mr1, mr2;
  logic [9:0]  lock_cnt;
  logic        relocked;
  logic [3:0]  sr_cnt;
  logic        slow_q;
  logic [4:0]  rd_dly;
  logic        rd_pend;
  logic [2:0]  beat;
  logic [11:0] rd_col;
  logic [3:0]  cl, cwl, al, rl;
  logic        live;

  assign cmd  = dlo_decode(lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n);
  assign live = lnk.cke && cke_q && !self_ref_o;

  // Latency decode: CL from MR0, CWL from MR2, AL from MR1
  assign cl  = {1'b0, mr0[6:4]} + 4'd4;
  assign cwl = {1'b0, mr2[5:3]} + 4'd5;
  always_comb begin
    case (mr1[4:3])
      2'b01:   al = cl - 4'd1;
      2'b10:   al = cl - 4'd2;
      default: al = 4'd0;
    endcase
  end
  // DLL off reads launch one cycle earlier than with the DLL on
  assign rl = dll_off_o ? al + cl - 4'd1 : al + cl;

  // Mode registers, written by MRS at any time outside self refresh
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mr0 <= '0;
      mr1 <= '0;
      mr2 <= '0;
    end else if (live && cmd == DLO_MRS) begin
      case (lnk.ba)
        3'd0:    mr0 <= lnk.addr;
        3'd1:    mr1 <= lnk.addr;
        3'd2:    mr2 <= lnk.addr;
        default: ;
      endcase
    end
  end
  assign dll_off_o = mr1[`DLO_MR1_DLL_DIS];

  // Only CL6 with CWL6 is valid with the DLL off
  assign lat_bad_o = dll_off_o && (cl != 4'(`DLO_CL_OFF) || cwl != 4'(`DLO_CWL_OFF));

  // DLL lock timer restarts on each DLL reset; counted in input edges
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_cnt <= '0;
      relocked <= 1'b0;
    end else if (dll_off_o) begin
      relocked <= 1'b0;
    end else if (live && cmd == DLO_MRS && lnk.ba == 3'd0 && lnk.addr[`DLO_MR0_DLL_RST]) begin
      lock_cnt <= 10'(`DLO_TDLLK_CYC);
      relocked <= 1'b1;
    end else if (lock_cnt != '0) begin
      lock_cnt <= lock_cnt - 1'b1;
    end
  end
  assign dll_locked_o = relocked && lock_cnt == '0 && !dll_off_o;

  // Self refresh: entered by REF with CKE falling, left when CKE rises
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cke_q      <= 1'b0;
      self_ref_o <= 1'b0;
      sr_cnt     <= '0;
    end else begin
      cke_q <= lnk.cke;
      if (!self_ref_o && cke_q && !lnk.cke && cmd == DLO_REF) begin
        self_ref_o <= 1'b1;
        sr_cnt     <= '0;
      end else if (self_ref_o && lnk.cke) begin
        self_ref_o <= 1'b0;
      end else if (self_ref_o && sr_cnt != 4'hf) begin
        sr_cnt <= sr_cnt + 1'b1;
      end
    end
  end

  // A rate change is legal only in self refresh once the hold time has passed
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slow_q    <= 1'b0;
      clk_err_o <= 1'b0;
    end else begin
      slow_q <= lnk.ck_slow;
      if (lnk.ck_slow != slow_q && !(self_ref_o && sr_cnt >= 4'(`DLO_TCKSRE_CYC)))
        clk_err_o <= 1'b1;
    end
  end

  // Read return: strobe and data move on the same edge, so the
  // strobe-to-data relation does not depend on the DLL state
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_dly     <= '0;
      rd_pend    <= 1'b0;
      beat       <= '0;
      rd_col     <= '0;
      lnk.rd_dqs <= 1'b0;
      lnk.rd_dq  <= '0;
    end else begin
      lnk.rd_dqs <= 1'b0;
      if (!rd_pend && beat == '0 && live && cmd == DLO_RD) begin
        rd_pend <= 1'b1;
        rd_dly  <= {1'b0, rl} - 5'd2; // First strobe leaves on edge RL after the command
        rd_col  <= lnk.addr[11:0];
      end else if (rd_pend && rd_dly != '0) begin
        rd_dly <= rd_dly - 1'b1;
      end else if (rd_pend) begin
        rd_pend <= 1'b0;
        beat    <= 3'd4;
      end
      if (beat != '0) begin
        beat       <= beat - 1'b1;
        lnk.rd_dqs <= 1'b1;
        lnk.rd_dq  <= {rd_col, 1'b0, beat};
      end
    end
  end
endmodule : dlo_dev
`default_nettype wire

// ---- logic/dlo_ctrl.sv ----
// Controller end: sequences DLL on/off switching through self refresh,
// reached by software over AXI4-Lite. Assumes the memory shares ref_clk_i.
`include "dlo_consts.svh"
`default_nettype none
module dlo_ctrl
  import dlo_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  dlo_if.ctl               lnk
);
  dlo_st_e            st, ret, next_st, next_ret;
  logic               tmr_load, tmr_done;
  logic [`DLO_TW-1:0] tmr_cnt;
  logic [3:0]         next_cmd;
  logic [2:0]         next_ba;
  logic [13:0]        next_addr;
  logic               next_cke;
  logic [9:0]         dllk_cnt;
  logic               tgt_off, zq_en, dll_off, done, go, rd_go;
  logic [15:0]        rdata;
  logic               wr_hs, wr_ctrl, wr_stat;
  logic               busy;

  assign busy = st != ST_IDLE;

  // Wait timer; every wait counts input clock edges
  dlo_tmr u_tmr (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .load_i    (tmr_load),
    .cnt_i     (tmr_cnt),
    .done_o    (tmr_done)
  );

  // Sequencer: issue states last one cycle, then park in ST_WAIT, except ST_RD, which moves to ST_WRD
  always_comb begin
    next_st   = st;
    next_ret  = ret;
    next_cmd  = 4'b0111; // NOP unless a step calls for a command
    next_ba   = 3'd0;
    next_addr = '0;
    next_cke  = lnk.cke;
    tmr_load  = 1'b0;
    tmr_cnt   = '0;
    case (st)
      ST_IDLE: begin
        if (go)
          next_st = tgt_off ? ST_MR1OFF : ST_SRE;
        else if (rd_go)
          next_st = ST_RD;
      end
      ST_MR1OFF: begin
        next_cmd  = 4'b0000;
        next_ba   = 3'd1;
        next_addr = `DLO_MR1_OFF;
        tmr_load  = 1'b1;
        tmr_cnt   = `DLO_TW'(`DLO_TMOD_CYC);
        next_ret  = ST_SRE;
        next_st   = ST_WAIT;
      end
      ST_SRE: begin
        next_cmd = 4'b0001;
        next_cke = 1'b0;
        tmr_load = 1'b1;
        tmr_cnt  = `DLO_TW'(`DLO_TCKSRE_CYC);
        next_ret = ST_CLKCHG;
        next_st  = ST_WAIT;
      end
      ST_CLKCHG: begin
        tmr_load = 1'b1;
        tmr_cnt  = `DLO_TW'(`DLO_TCKSRX_CYC);
        next_ret = ST_SRX;
        next_st  = ST_WAIT;
      end
      ST_SRX: begin
        next_cke = 1'b1; // Stays high to the end of the sequence
        tmr_load = 1'b1;
        tmr_cnt  = `DLO_TW'(`DLO_TXS_CYC);
        next_ret = tgt_off ? ST_MR2 : ST_MR1ON;
        next_st  = ST_WAIT;
      end
      ST_MR1ON: begin
        next_cmd  = 4'b0000;
        next_ba   = 3'd1;
        next_addr = `DLO_MR1_ON;
        tmr_load  = 1'b1;
        tmr_cnt   = `DLO_TW'(`DLO_TMRD_CYC);
        next_ret  = ST_MR0RST;
        next_st   = ST_WAIT;
      end
      ST_MR0RST: begin
        next_cmd  = 4'b0000;
        next_addr = `DLO_MR0_RST;
        tmr_load  = 1'b1;
        tmr_cnt   = `DLO_TW'(`DLO_TMRD_CYC);
        next_ret  = ST_MR2;
        next_st   = ST_WAIT;
      end
      ST_MR2: begin
        next_cmd  = 4'b0000;
        next_ba   = 3'd2;
        next_addr = tgt_off ? `DLO_MR2_OFF : `DLO_MR2_ON;
        tmr_load  = 1'b1;
        tmr_cnt   = `DLO_TW'(`DLO_TMRD_CYC);
        next_ret  = ST_MR0;
        next_st   = ST_WAIT;
      end
      ST_MR0: begin
        next_cmd  = 4'b0000;
        next_addr = tgt_off ? `DLO_MR0_OFF : `DLO_MR0_ON;
        tmr_load  = 1'b1;
        tmr_cnt   = `DLO_TW'(`DLO_TMOD_CYC);
        next_ret  = zq_en ? ST_ZQ : ST_FIN;
        next_st   = ST_WAIT;
      end
      ST_ZQ: begin
        next_cmd     = 4'b0110;
        next_addr[10] = 1'b1; // Long calibration, after tMOD
        tmr_load     = 1'b1;
        tmr_cnt      = `DLO_TW'(`DLO_TZQOPER_CYC);
        next_ret     = ST_FIN;
        next_st      = ST_WAIT;
      end
      ST_FIN: begin
        if (dllk_cnt == '0) // Lock time must also be over
          next_st = ST_IDLE;
      end
      ST_RD: begin
        next_cmd = 4'b0101;
        next_st  = ST_WRD;
      end
      ST_WRD: begin
        if (lnk.rd_dqs)
          next_st = ST_IDLE;
      end
      ST_WAIT: begin
        if (tmr_done)
          next_st = ret;
      end
      default: next_st = ST_IDLE;
    endcase
  end

  // State and registered link pins; ODT is never raised here
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st        <= ST_IDLE;
      ret       <= ST_IDLE;
      lnk.cke   <= 1'b1;
      lnk.cs_n  <= 1'b1;
      lnk.ras_n <= 1'b1;
      lnk.cas_n <= 1'b1;
      lnk.we_n  <= 1'b1;
      lnk.ba    <= '0;
      lnk.addr  <= '0;
      lnk.odt   <= 1'b0;
    end else begin
      st        <= next_st;
      ret       <= next_ret;
      lnk.cke   <= next_cke;
      {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n} <= next_cmd;
      lnk.ba    <= next_ba;
      lnk.addr  <= next_addr;
      lnk.odt   <= 1'b0;
    end
  end

  // Clock rate select changes only while parked in self refresh
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lnk.ck_slow <= 1'b0;
      dll_off     <= 1'b0;
    end else if (st == ST_CLKCHG) begin
      lnk.ck_slow <= tgt_off; // Slow rate for as long as the DLL is off
      dll_off     <= tgt_off;
    end
  end

  // Lock timer runs beside the sequence from the DLL reset command
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      dllk_cnt <= '0;
    else if (st == ST_MR0RST)
      dllk_cnt <= 10'(`DLO_TDLLK_CYC);
    else if (dllk_cnt != '0)
      dllk_cnt <= dllk_cnt - 1'b1;
  end

  // Read data is captured on our own clock when the strobe shows up,
  // since its arrival time floats with the DLL off
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      rdata <= '0;
    else if (st == ST_WRD && lnk.rd_dqs)
      rdata <= lnk.rd_dq;
  end

  // AXI write: address and data are taken together, one at a time
  assign wr_hs         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_hs;
  assign s_axi_wready  = wr_hs;
  assign wr_ctrl       = wr_hs && s_axi_awaddr == `DLO_REG_CTRL && s_axi_wstrb[0];
  assign wr_stat       = wr_hs && s_axi_awaddr == `DLO_REG_STAT && s_axi_wstrb[0];

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_hs) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (s_axi_awaddr == `DLO_REG_CTRL || s_axi_awaddr == `DLO_REG_STAT
                       || s_axi_awaddr == `DLO_REG_RDATA) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control bits; start strobes are ignored while a sequence runs
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tgt_off <= 1'b0;
      zq_en   <= 1'b0;
      go      <= 1'b0;
      rd_go   <= 1'b0;
    end else begin
      go    <= wr_ctrl && !busy && s_axi_wdata[`DLO_CTRL_GO];
      rd_go <= wr_ctrl && !busy && s_axi_wdata[`DLO_CTRL_RD];
      if (wr_ctrl && !busy) begin
        tgt_off <= s_axi_wdata[`DLO_CTRL_OFF];
        zq_en   <= s_axi_wdata[`DLO_CTRL_ZQ];
      end
    end
  end

  // Sticky done flag: write one clears, a new completion wins
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      done <= 1'b0;
    else if (st == ST_FIN && next_st == ST_IDLE)
      done <= 1'b1;
    else if (wr_stat && s_axi_wdata[`DLO_STAT_DONE])
      done <= 1'b0;
  end

  // AXI read
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case (s_axi_araddr)
        `DLO_REG_CTRL:  s_axi_rdata <= {29'd0, zq_en, tgt_off, 1'b0};
        `DLO_REG_STAT:  s_axi_rdata <= {28'd0, lnk.ck_slow, done, dll_off, busy};
        `DLO_REG_RDATA: s_axi_rdata <= {16'd0, rdata};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : dlo_ctrl
`default_nettype wire

// ---- verification/dlo_monitor.sv ----
// Checker for the DLL switching link; it sees only the wires of dlo_if.
// Assumes both ends share ref_clk_i and the bench instantiates it beside the link.
`default_nettype none
module dlo_monitor (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [13:0] addr,
  input  wire logic        odt,
  input  wire logic        ck_slow,
  input  wire logic        rd_dqs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic nop, mrs, refc, rdc;

  // Local decode, so that a decode slip in the design is not copied here
  assign nop  = cs_n | (ras_n & cas_n & we_n);
  assign mrs  = !cs_n & !ras_n & !cas_n & !we_n;
  assign refc = !cs_n & !ras_n & !cas_n & we_n;
  assign rdc  = !cs_n & ras_n & !cas_n & we_n;

  default clocking mon_cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // Sequencing of the switch; waits allow one transit cycle of slack
  odt_low_a: assert property (odt == 1'b0)
    else $error("odt driven high");
  sr_entry_a: assert property ($fell(cke) |-> refc)
    else $error("cke fell without self refresh entry");
  sr_nop_a: assert property (!cke && !$fell(cke) |-> nop)
    else $error("command issued in self refresh");
  clk_change_a: assert property ($changed(ck_slow) |-> !cke && !$past(cke, 5))
    else $error("clock rate changed too early");
  srx_stable_a: assert property ($rose(cke) |-> ck_slow == $past(ck_slow, 5))
    else $error("clock not stable before exit");
  txs_wait_a: assert property ($rose(cke) |-> (cke && nop)[*8] ##1 (cke && nop)[*8]
    ##1 (cke && nop)[*6] ##[1:20] mrs) else $error("exit delay broken");
  mod_wait_a: assert property (mrs && ba == 3'h1 && addr[0] |=> (cke && nop)[*8]
    ##1 (cke && nop)[*3] ##[1:10] (refc && !cke)) else $error("entry after disable broken");
  mrd_gap_a: assert property (mrs |=> (!mrs)[*3])
    else $error("mode writes too close");
  dll_reset_a: assert property (mrs && ba == 3'h1 && !addr[0] |-> ##[4:6] (mrs && ba == 3'h0 && addr[8]))
    else $error("loop reset not issued");
  rd_off_lat_a: assert property (rdc && ck_slow |=> (!rd_dqs)[*3] ##[1:3] rd_dqs[*4])
    else $error("slow mode read latency");
  rd_on_lat_a: assert property (rdc && !ck_slow |=> (!rd_dqs)[*7] ##[1:3] rd_dqs[*4])
    else $error("normal mode read latency");

  // Main scenarios reached
  cover property ($rose(ck_slow));
  cover property ($fell(ck_slow));
  cover property (mrs && addr[8]);
  cover property ($rose(rd_dqs));
endmodule : dlo_monitor
`default_nettype wire

// ---- verification/dll_off_mode_switching_tb.sv ----
// Self-checking bench: controller and memory model joined by dlo_if.
// Assumes one 125 MHz clock; software side driven as an AXI4-Lite master.
`include "dlo_consts.svh"
`default_nettype none
module dll_off_mode_switching_tb;
  import dlo_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i, rstn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        dll_off, dll_locked, self_ref, lat_bad, clk_err;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_w;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          num_errors, n_checks, cyc;

  dlo_if lnk ();
  dlo_ctrl i_dlo_ctrl (.ref_clk_i, .rstn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lnk(lnk));
  dlo_dev i_dlo_dev (.ref_clk_i, .rstn_i, .lnk(lnk), .dll_off_o(dll_off), .dll_locked_o(dll_locked),
    .self_ref_o(self_ref), .lat_bad_o(lat_bad), .clk_err_o(clk_err));
  dlo_monitor i_dlo_monitor (.ref_clk_i, .rstn_i, .cke(lnk.cke), .cs_n(lnk.cs_n), .ras_n(lnk.ras_n),
    .cas_n(lnk.cas_n), .we_n(lnk.we_n), .ba(lnk.ba), .addr(lnk.addr), .odt(lnk.odt), .ck_slow(lnk.ck_slow),
    .rd_dqs(lnk.rd_dqs));

  // Clock and a watchdog; the ceiling is more than ten times the longest expected run
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_word

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: response %b exp %b", $time, g, e);
    end
  endtask : chk_resp

  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge ref_clk_i);
      if (s_axi_awready && !aw_d) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_d) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk_i); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge ref_clk_i);
  endtask : axi_wr

  // Read; the extra edge keeps a following request off the release step
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk_i); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk_i);
  endtask : axi_rd

  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    axi_rd(a, rd_w, resp);
    chk_resp(resp, 2'b00);
    chk_word(rd_w, e, "register");
  endtask : rd_reg

  // Polls status; only the watchdog ends a hang
  task automatic wait_bit(input int b, input logic v);
    do axi_rd(`DLO_REG_STAT, rd_w, resp); while (rd_w[b] !== v);
  endtask : wait_bit

  // Read burst: controller keeps the first beat, beat number 4 in the low bits
  task automatic t_read(input logic [31:0] c);
    axi_wr(`DLO_REG_CTRL, c, resp);
    wait_bit(`DLO_STAT_BUSY, 1'b0);
    axi_rd(`DLO_REG_RDATA, rd_w, resp);
    chk_word(rd_w & 32'hFFFF_000F, 32'h0000_0004, "read beat");
  endtask : t_read

  task automatic t_dll_off();
    axi_wr(`DLO_REG_CTRL, 32'h0000_0007, resp);
    axi_wr(`DLO_REG_CTRL, 32'h0000_0001, resp);
    rd_reg(`DLO_REG_CTRL, 32'h0000_0006);
    wait_bit(`DLO_STAT_DONE, 1'b1);
    rd_reg(`DLO_REG_STAT, 32'h0000_000E);
    chk_word(32'(dll_off), 32'h0000_0001, "loop off");
    chk_word(32'(lat_bad | clk_err), 32'h0000_0000, "latency or clock");
    axi_wr(`DLO_REG_STAT, 32'h0000_0004, resp);
    rd_reg(`DLO_REG_STAT, 32'h0000_000A);
  endtask : t_dll_off

  task automatic t_dll_on();
    axi_wr(`DLO_REG_CTRL, 32'h0000_0001, resp);
    wait_bit(`DLO_STAT_DONE, 1'b1);
    rd_reg(`DLO_REG_STAT, 32'h0000_0004);
    chk_word(32'({dll_off, dll_locked, clk_err}), 32'h0000_0002, "loop on");
  endtask : t_dll_on

  // Reset in the middle of self refresh must leave the link idle
  task automatic t_mid_reset();
    axi_wr(`DLO_REG_CTRL, 32'h0000_0003, resp);
    do @(posedge ref_clk_i); while (lnk.cke !== 1'b0);
    @(posedge ref_clk_i);
    chk_word(32'(self_ref), 32'h0000_0001, "self refresh entered");
    rstn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    chk_word(32'({lnk.cke, lnk.odt, lnk.ck_slow, dll_off, self_ref}), 32'h0000_0010, "after reset");
    rd_reg(`DLO_REG_STAT, 32'h0000_0000);
  endtask : t_mid_reset

  // Idle status after reset, then an unmapped offset must be refused
  task automatic t_unmapped();
    rd_reg(`DLO_REG_STAT, 32'h0000_0000);
    axi_wr(4'hC, 32'h0000_0001, resp);
    chk_resp(resp, 2'b10);
    axi_rd(4'hC, rd_w, resp);
    chk_resp(resp, 2'b10);
    chk_word(rd_w, 32'h0000_0000, "unmapped");
  endtask : t_unmapped

  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    num_errors = 0;
    n_checks = 0;
    cyc = 0;
    rstn_i = 1'b1;
    #1 rstn_i = 1'b0; // A real falling edge, so neither end can miss reset at time zero
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    t_unmapped();
    t_dll_off();
    t_read(32'h0000_000A);
    t_dll_on();
    t_read(32'h0000_0008);
    t_mid_reset();
    complete_run();
  end
endmodule : dll_off_mode_switching_tb
`default_nettype wire
